// [verilog/ppp_device.sv]
// device end of the parallel program port: command decode, buffers, arrays
// Summary of operation
// - command loads with action select 10
// - action 00 loads address low/high byte
// - action 01 loads data low/high byte
// - 0x10 writes flash via latched page buffer
// - write strobe programs flash page, busy low
// - host waits ready, repeats page by page
// - 0x00 no-op resets internal write signals
// - 0x11 writes eeprom via latched page buffer
// - write strobe programs eeprom page, busy low
// - 0x02 reads flash word low/high byte
// - 0x03 reads addressed eeprom byte
// - 0x40 fuse write, selects pick fuse byte
// - fuse data zero programs, one erases
// - host returns byte select one low
// - 0x20 lock write; only erase or reset clears
// - 0x04 reads fuse low, high or lock
// - 0x08 low address 0..2 gives signature
// - 0x08 with select one gives calibration
// - writes finish within 3.7 to 4.5 ms
// - chip erase finishes within 7.5 to 9 ms
`timescale 1ns/1ps
module ppp_device
    import ppp_pkg::*;
#(
    parameter logic [7:0] SIG0 = 8'h1e,   // arbitrary identity value
    parameter logic [7:0] SIG1 = 8'h95,   // arbitrary identity value
    parameter logic [7:0] SIG2 = 8'h02,   // arbitrary identity value
    parameter logic [7:0] CALIB = 8'h80,  // arbitrary calibration value
    parameter logic [PPP_CNT_W-1:0] WRITE_CNT = PPP_CNT_W'(WRITE_CYCLES),
    parameter logic [PPP_CNT_W-1:0] ERASE_CNT = PPP_CNT_W'(ERASE_CYCLES)
)(
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    ppp_if.dev               pins,
    output logic [7:0]       command_out,
    output logic             busy_out
);
    import ppp_pkg::*;

    localparam int FW = 1 << PPP_FLASH_AW;
    localparam int EW = 1 << PPP_EE_AW;
    localparam int PW = 1 << PPP_PAGE_AW;

    logic [15:0] flash_mem [FW];
    logic [7:0]  ee_mem    [EW];
    logic [15:0] fpage     [PW];
    logic [7:0]  epage     [PW];
    logic [PW-1:0] fvalid;
    logic [PW-1:0] evalid;
    logic [7:0]  command;
    logic [7:0]  addr_lo;
    logic [7:0]  addr_hi;
    logic [7:0]  data_lo;
    logic [7:0]  data_hi;
    logic [7:0]  fuse_lo;
    logic [7:0]  fuse_hi;
    logic [7:0]  lock_bits;
    logic        ld_d, pl_d, wr_d;
    logic [7:0]  rd_data;
    logic        rd_oe_n;
    logic        tmr_start, tmr_busy, tmr_done;
    logic [PPP_CNT_W-1:0] tmr_cycles;
    logic        pend_flash, pend_ee, pend_erase;
    logic [7:0]  pend_page;

    // edge detection of the host strobes (inputs are synchronous)
    wire ld_rise = pins.load_strobe && !ld_d;
    wire pl_rise = pins.page_latch_strobe && !pl_d;
    wire wr_fall = !pins.write_n && wr_d;
    wire bs1     = pins.byte_select_one;
    wire bs2     = pins.byte_select_two;
    wire [PPP_PAGE_AW-1:0] word_idx = addr_lo[PPP_PAGE_AW-1:0];
    wire [7:0]   ee_addr = addr_lo;
    wire [7:0]   fl_addr = addr_lo;
    // busy masks write strobes and loads; page latch strobes still reach the page buffers
    wire ld_ok   = ld_rise && !tmr_busy;
    wire wr_ok   = wr_fall && !tmr_busy;
    wire start_wr = wr_ok && !bs1 && (command == PPP_CMD_WR_FLASH
                                   || command == PPP_CMD_WR_EE);
    wire start_fuse = wr_ok && command == PPP_CMD_WR_FUSE && !bs2;
    wire start_lock = wr_ok && command == PPP_CMD_WR_LOCK;
    wire start_erase = wr_ok && command == PPP_CMD_ERASE;

    assign tmr_start  = start_wr || start_fuse || start_lock || start_erase;
    assign tmr_cycles = start_erase ? ERASE_CNT : WRITE_CNT;
    assign busy_out   = tmr_busy;
    assign command_out = command;
    assign pins.ready_busy_flag = !tmr_busy;
    assign pins.dev_data = rd_data;
    assign pins.dev_data_oe_n = rd_oe_n;

    ppp_busy_timer u_timer (
        .clk_in    (clk_in),
        .rst_in    (rst_in),
        .start_in  (tmr_start),
        .cycles_in (tmr_cycles),
        .busy_out  (tmr_busy),
        .done_out  (tmr_done)
    );

    // strobe history
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ld_d <= 1'b0;
            pl_d <= 1'b0;
            wr_d <= 1'b1;
        end else begin
            ld_d <= pins.load_strobe;
            pl_d <= pins.page_latch_strobe;
            wr_d <= pins.write_n;
        end
    end

    // command, address and data byte loads
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            command <= PPP_CMD_NOP;
            addr_lo <= 8'h00;
            addr_hi <= 8'h00;
            data_lo <= 8'h00;
            data_hi <= 8'h00;
        end else if (ld_ok) begin
            case (pins.action_select)
                PPP_ACT_CMD:  command <= pins.host_data;
                PPP_ACT_ADDR: begin
                    if (bs1) addr_hi <= pins.host_data;
                    else     addr_lo <= pins.host_data;
                end
                PPP_ACT_DATA: begin
                    if (bs1) data_hi <= pins.host_data;
                    else     data_lo <= pins.host_data;
                end
                default: ;
            endcase
        end
    end

    // page buffers: latch on page strobe, cleared by no-op or commit
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            fvalid <= '0;
            evalid <= '0;
        end else if (ld_ok && pins.action_select == PPP_ACT_CMD
                     && pins.host_data == PPP_CMD_NOP) begin
            fvalid <= '0;
            evalid <= '0;
        end else begin
            if (tmr_done) begin
                fvalid <= '0;
                evalid <= '0;
            end
            if (pl_rise && command == PPP_CMD_WR_FLASH) begin
                fpage[word_idx]  <= {data_hi, data_lo};
                fvalid[word_idx] <= 1'b1;
            end else if (pl_rise && command == PPP_CMD_WR_EE) begin
                epage[word_idx]  <= data_lo;
                evalid[word_idx] <= 1'b1;
            end
        end
    end

    // pending commit, applied when the busy time has elapsed
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pend_flash <= 1'b0;
            pend_ee    <= 1'b0;
            pend_erase <= 1'b0;
            pend_page  <= 8'h00;
        end else if (start_wr || start_erase) begin
            pend_flash <= command == PPP_CMD_WR_FLASH;
            pend_ee    <= command == PPP_CMD_WR_EE;
            pend_erase <= start_erase;
            pend_page  <= addr_lo;
        end else if (tmr_done) begin
            pend_flash <= 1'b0;
            pend_ee    <= 1'b0;
            pend_erase <= 1'b0;
        end
    end

    // array update at end of busy; page offset from latched low address
    always_ff @(posedge clk_in) begin
        if (tmr_done && pend_erase) begin
            for (int i = 0; i < FW; i++) flash_mem[i] <= {PPP_ERASED, PPP_ERASED};
            for (int i = 0; i < EW; i++) ee_mem[i] <= PPP_ERASED;
        end else if (tmr_done) begin
            for (int i = 0; i < PW; i++) begin
                if (pend_flash && fvalid[i])
                    flash_mem[{pend_page[7:PPP_PAGE_AW], 4'(i)}] <= fpage[i];
                if (pend_ee && evalid[i])
                    ee_mem[{pend_page[7:PPP_PAGE_AW], 4'(i)}] <= epage[i];
            end
        end
    end

    // fuse and lock bytes: zero programs, one erases; locks only set
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            fuse_lo   <= PPP_FUSE_LO_RST;
            fuse_hi   <= PPP_FUSE_HI_RST;
            lock_bits <= PPP_ERASED;
        end else if (start_fuse && !bs1) begin
            fuse_lo <= data_lo;
        end else if (start_fuse && bs1) begin
            fuse_hi <= data_lo;
        end else if (start_lock) begin
            lock_bits <= lock_bits & data_lo;
        end else if (tmr_done && pend_erase) begin
            lock_bits <= PPP_ERASED;
        end
    end

    // read mux, registered; bus released while output enable is high
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rd_data <= 8'h00;
            rd_oe_n <= 1'b1;
        end else begin
            rd_oe_n <= pins.out_enable_n;
            case (command)
                PPP_CMD_RD_FLASH: rd_data <= bs1 ? flash_mem[fl_addr][15:8]
                                                 : flash_mem[fl_addr][7:0];
                PPP_CMD_RD_EE:    rd_data <= ee_mem[ee_addr];
                PPP_CMD_RD_FL: begin
                    if (!bs1)     rd_data <= fuse_lo;
                    else if (bs2) rd_data <= fuse_hi;
                    else          rd_data <= lock_bits;
                end
                PPP_CMD_RD_SIG: begin
                    if (bs1)                  rd_data <= CALIB;
                    else if (addr_lo == 8'h00) rd_data <= SIG0;
                    else if (addr_lo == 8'h01) rd_data <= SIG1;
                    else if (addr_lo == PPP_SIG_LAST) rd_data <= SIG2;
                    else                      rd_data <= PPP_ERASED;
                end
                default:          rd_data <= PPP_ERASED;
            endcase
        end
    end
endmodule

// [verilog/ppp_pkg.sv]
// shared constants and types for the parallel program port
package ppp_pkg;
    // action select codes
    localparam logic [1:0] PPP_ACT_ADDR = 2'h0;
    localparam logic [1:0] PPP_ACT_DATA = 2'h1;
    localparam logic [1:0] PPP_ACT_CMD  = 2'h2;
    // command bytes
    localparam logic [7:0] PPP_CMD_NOP      = 8'h00;
    localparam logic [7:0] PPP_CMD_WR_FLASH = 8'h10;
    localparam logic [7:0] PPP_CMD_WR_EE    = 8'h11;
    localparam logic [7:0] PPP_CMD_RD_FLASH = 8'h02;
    localparam logic [7:0] PPP_CMD_RD_EE    = 8'h03;
    localparam logic [7:0] PPP_CMD_WR_FUSE  = 8'h40;
    localparam logic [7:0] PPP_CMD_WR_LOCK  = 8'h20;
    localparam logic [7:0] PPP_CMD_RD_FL    = 8'h04;
    localparam logic [7:0] PPP_CMD_RD_SIG   = 8'h08;
    localparam logic [7:0] PPP_CMD_ERASE    = 8'h80;
    // memory geometry (small model arrays)
    localparam int PPP_FLASH_AW = 8;
    localparam int PPP_EE_AW    = 8;
    localparam int PPP_PAGE_AW  = 4;
    // reset values of nonvolatile bytes (erased state, fuse defaults) and the last signature address
    localparam logic [7:0] PPP_ERASED       = 8'hff;
    localparam logic [7:0] PPP_FUSE_LO_RST  = 8'he1;
    localparam logic [7:0] PPP_FUSE_HI_RST  = 8'h99;
    localparam logic [7:0] PPP_SIG_LAST     = 8'h02;
    // busy timing
    localparam int CLK_HZ         = 10_000_000;
    localparam int WRITE_TIME_US  = 4100;   // inside 3.7 .. 4.5 ms
    localparam int ERASE_TIME_US  = 8250;   // inside 7.5 .. 9 ms
    localparam int WRITE_CYCLES   = WRITE_TIME_US * (CLK_HZ / 1_000_000);
    localparam int ERASE_CYCLES   = ERASE_TIME_US * (CLK_HZ / 1_000_000);
    localparam int PPP_CNT_W      = 17;
    // host operation codes (load, latch, write, read)
    typedef enum logic [1:0] {
        PPP_OP_LOAD,
        PPP_OP_LATCH,
        PPP_OP_WRITE,
        PPP_OP_READ
    } ppp_op_t;
endpackage

// [verilog/ppp_if.sv]
// pin bundle between the programmer and the programmed device
`timescale 1ns/1ps
interface ppp_if;
    logic [1:0] action_select;      // {action_select_hi, action_select_lo}
    logic       byte_select_one;
    logic       byte_select_two;
    logic       load_strobe;
    logic       page_latch_strobe;
    logic       write_n;
    logic       out_enable_n;
    logic [7:0] host_data;
    logic [7:0] dev_data;
    logic       dev_data_oe_n;      // low while the device drives the bus
    logic       ready_busy_flag;
    logic [7:0] bus_data;
    assign bus_data = dev_data_oe_n ? host_data : dev_data;
    modport dev (
        input  action_select, byte_select_one, byte_select_two, load_strobe,
        input  page_latch_strobe, write_n, out_enable_n, host_data,
        output dev_data, dev_data_oe_n, ready_busy_flag
    );
    modport host (
        output action_select, byte_select_one, byte_select_two, load_strobe,
        output page_latch_strobe, write_n, out_enable_n, host_data,
        input  bus_data, dev_data_oe_n, ready_busy_flag
    );
endinterface

// [verilog/ppp_busy_timer.sv]
// down counter that holds busy for a programmed number of cycles
`timescale 1ns/1ps
module ppp_busy_timer
    import ppp_pkg::*;
(
    input  wire logic                 clk_in,
    input  wire logic                 rst_in,
    input  wire logic                 start_in,
    input  wire logic [PPP_CNT_W-1:0] cycles_in,
    output logic                      busy_out,
    output logic                      done_out
);
    logic [PPP_CNT_W-1:0] count;
    assign busy_out = (count != '0);
    assign done_out = (count == PPP_CNT_W'(1));
    // start only accepted when idle, so a running cycle is never restarted
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            count <= '0;
        end else if (start_in && !busy_out) begin
            count <= cycles_in;
        end else if (busy_out) begin
            count <= count - PPP_CNT_W'(1);
        end
    end
endmodule

// [verilog/ppp_host.sv]
// programmer end: turns user requests into strobe sequences on the pins
`timescale 1ns/1ps
module ppp_host
    import ppp_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    ppp_if.host              pins,
    input  wire logic        req_valid_in,
    input  wire ppp_op_t     req_op_in,
    input  wire logic [1:0]  req_action_in,
    input  wire logic        req_bs1_in,
    input  wire logic        req_bs2_in,
    input  wire logic [7:0]  req_data_in,
    output logic             req_ready_out,
    output logic [7:0]       rsp_data_out,
    output logic             rsp_valid_out
);
    import ppp_pkg::*;

    typedef enum logic [2:0] { PPP_H_IDLE, PPP_H_SETUP, PPP_H_PULSE, PPP_H_HOLD,
                               PPP_H_WAIT } ppp_hstate_t;
    ppp_hstate_t state;
    ppp_op_t     op;
    logic [1:0]  cnt;

    // requests only accepted while idle and the device reports ready
    assign req_ready_out = (state == PPP_H_IDLE) && pins.ready_busy_flag;

    // sequencer: setup, 2-cycle strobe (200 ns > 150 ns), hold
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state <= PPP_H_IDLE;
            op <= PPP_OP_LOAD;
            cnt <= 2'h0;
            pins.action_select <= PPP_ACT_CMD;
            pins.byte_select_one <= 1'b0;
            pins.byte_select_two <= 1'b0;
            pins.load_strobe <= 1'b0;
            pins.page_latch_strobe <= 1'b0;
            pins.write_n <= 1'b1;
            pins.out_enable_n <= 1'b1;
            pins.host_data <= 8'h00;
            rsp_data_out <= 8'h00;
            rsp_valid_out <= 1'b0;
        end else begin
            rsp_valid_out <= 1'b0;
            case (state)
                PPP_H_IDLE: if (req_valid_in && req_ready_out) begin
                    op <= req_op_in;
                    pins.action_select <= req_action_in;
                    pins.byte_select_one <= req_bs1_in;
                    pins.byte_select_two <= req_bs2_in;
                    pins.host_data <= req_data_in;
                    state <= PPP_H_SETUP;
                end
                PPP_H_SETUP: begin
                    cnt <= 2'h1;
                    state <= PPP_H_PULSE;
                    case (op)
                        PPP_OP_LOAD:  pins.load_strobe <= 1'b1;
                        PPP_OP_LATCH: pins.page_latch_strobe <= 1'b1;
                        PPP_OP_WRITE: pins.write_n <= 1'b0;
                        PPP_OP_READ:  pins.out_enable_n <= 1'b0;
                        default: ;
                    endcase
                end
                PPP_H_PULSE: if (cnt == 2'h0) begin
                    pins.load_strobe <= 1'b0;
                    pins.page_latch_strobe <= 1'b0;
                    pins.write_n <= 1'b1;
                    if (op == PPP_OP_READ) begin
                        rsp_data_out <= pins.bus_data;
                        rsp_valid_out <= 1'b1;
                        pins.out_enable_n <= 1'b1;
                    end
                    state <= PPP_H_HOLD;
                end else begin
                    cnt <= cnt - 2'h1;
                end
                PPP_H_HOLD: begin
                    state <= (op == PPP_OP_WRITE) ? PPP_H_WAIT : PPP_H_IDLE;
                    if (op == PPP_OP_WRITE) pins.byte_select_one <= 1'b0;
                end
                PPP_H_WAIT: if (pins.ready_busy_flag) begin
                    state <= PPP_H_IDLE;
                end
                default: state <= PPP_H_IDLE;
            endcase
        end
    end
endmodule

// [verif/ppp_port_checker.sv]
// concurrent checks on the pins between programmer and device
`timescale 1ns/1ps
module ppp_port_checker
    import ppp_pkg::*;
#(
    parameter int WRITE_CNT = 20,
    parameter int ERASE_CNT = 40
)(
    input wire logic       clk_in,
    input wire logic       rst_in,
    input wire logic [1:0] action_select,
    input wire logic       byte_select_one,
    input wire logic       byte_select_two,
    input wire logic       load_strobe,
    input wire logic       write_n,
    input wire logic       out_enable_n,
    input wire logic [7:0] host_data,
    input wire logic       dev_data_oe_n,
    input wire logic       ready_busy_flag
);
    // busy windows scaled from the nominal 4.1 ms and 8.25 ms settings
    localparam int W_MIN    = (WRITE_CNT * 370 + 409) / 410;
    localparam int W_MAX    = (WRITE_CNT * 450) / 410;
    localparam int E_MIN    = (ERASE_CNT * 750 + 824) / 825;
    localparam int E_MAX    = (ERASE_CNT * 900) / 825;
    localparam int BUSY_MAX = ERASE_CNT + 4;

    logic [7:0] cmd_q;
    logic       ld_q;
    logic       wr_q;
    logic       erase_q;
    logic [7:0] low_cnt;

    // strobe edges seen the way the device sees them, against the previous sample
    wire ld_rise  = load_strobe && !ld_q;
    wire wr_fall  = !write_n && wr_q;
    wire is_pgm   = (cmd_q == PPP_CMD_WR_FLASH || cmd_q == PPP_CMD_WR_EE) && !byte_select_one;
    wire is_wr    = is_pgm || (cmd_q == PPP_CMD_WR_FUSE && !byte_select_two)
                    || cmd_q == PPP_CMD_WR_LOCK || cmd_q == PPP_CMD_ERASE;
    wire wr_start = wr_fall && ready_busy_flag && is_wr;

    // shadow of the command byte; loads during busy are dropped as the device must
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cmd_q   <= PPP_CMD_NOP;
            ld_q    <= 1'h0;
            wr_q    <= 1'h1;
            erase_q <= 1'h0;
            low_cnt <= 8'h00;
        end else begin
            ld_q    <= load_strobe;
            wr_q    <= write_n;
            low_cnt <= ready_busy_flag ? 8'h00 : low_cnt + 8'h01;
            if (ld_rise && ready_busy_flag && action_select == PPP_ACT_CMD) begin
                cmd_q <= host_data;
            end
            if (wr_start) begin
                erase_q <= (cmd_q == PPP_CMD_ERASE);
            end
        end
    end

    chk_busy_start: assert property (@(posedge clk_in) disable iff (rst_in)
        wr_start |=> !ready_busy_flag) else $error("busy did not follow write strobe");
    chk_busy_cause: assert property (@(posedge clk_in) disable iff (rst_in)
        $fell(ready_busy_flag) |-> $past(wr_start)) else $error("busy without valid write");
    chk_busy_hold: assert property (@(posedge clk_in) disable iff (rst_in)
        $fell(ready_busy_flag) |-> (!ready_busy_flag) [*8]) else $error("busy dropped early");
    chk_write_time: assert property (@(posedge clk_in) disable iff (rst_in)
        $rose(ready_busy_flag) && !erase_q |-> low_cnt >= W_MIN && low_cnt <= W_MAX)
        else $error("write busy length out of range");
    chk_erase_time: assert property (@(posedge clk_in) disable iff (rst_in)
        $rose(ready_busy_flag) && erase_q |-> low_cnt >= E_MIN && low_cnt <= E_MAX)
        else $error("erase busy length out of range");
    chk_busy_bounded: assert property (@(posedge clk_in) disable iff (rst_in)
        $fell(ready_busy_flag) |-> ##[1:BUSY_MAX] ready_busy_flag) else $error("busy hung");
    chk_bus_release: assert property (@(posedge clk_in) disable iff (rst_in)
        out_enable_n |=> dev_data_oe_n) else $error("bus not released");
    chk_bus_drive: assert property (@(posedge clk_in) disable iff (rst_in)
        !out_enable_n |=> !dev_data_oe_n) else $error("bus not driven on read");

    cover property (@(posedge clk_in) wr_start && cmd_q == PPP_CMD_ERASE);
    cover property (@(posedge clk_in) wr_start && cmd_q == PPP_CMD_WR_FLASH);
    cover property (@(posedge clk_in) !out_enable_n && !dev_data_oe_n);
endmodule

// [verif/ppp_tb_top.sv]
// testbench top: programmer end driving the device end through the pin bundle
`timescale 1ns/1ps
module parallel_program_port_tb_top;
    import ppp_pkg::*;
    localparam int         WR_CNT = 20;     // short busy counts keep the run brief
    localparam int         ER_CNT = 40;
    localparam logic [7:0] SIG0   = 8'h3a;  // arbitrary identity value
    localparam logic [7:0] SIG1   = 8'hc5;  // arbitrary identity value
    localparam logic [7:0] SIG2   = 8'h17;  // arbitrary identity value
    localparam logic [7:0] CALIB  = 8'h6c;  // arbitrary calibration value
    localparam logic [1:0] C = PPP_ACT_CMD;
    localparam logic [1:0] A = PPP_ACT_ADDR;
    localparam logic [1:0] D = PPP_ACT_DATA;
    localparam ppp_op_t    LD = PPP_OP_LOAD;
    localparam ppp_op_t    LT = PPP_OP_LATCH;
    localparam ppp_op_t    WR = PPP_OP_WRITE;
    localparam ppp_op_t    RD = PPP_OP_READ;
    // sel is {byte_select_two, byte_select_one}; exp only matters for reads
    typedef struct {ppp_op_t op; logic [1:0] act; logic [1:0] sel; logic [7:0] d;
                    logic [7:0] exp;} ppp_row_t;

    logic       clk_in;
    logic       rst_in;
    logic       req_valid;
    ppp_op_t    req_op;
    logic [1:0] req_action;
    logic       req_bs1;
    logic       req_bs2;
    logic [7:0] req_data;
    logic       req_ready;
    logic [7:0] rsp_data;
    logic       rsp_valid;
    logic [7:0] cmd_seen;
    logic       busy_seen;
    logic [7:0] rd_data;
    int         error_cnt = 0;
    int         tests_run = 0;
    int         cycles    = 0;

    ppp_row_t rows [] = '{
        '{LD, C, 2'h0, PPP_CMD_RD_FL, 8'h00}, '{RD, C, 2'h0, 8'h00, 8'he1},
        '{RD, C, 2'h3, 8'h00, 8'h99}, '{RD, C, 2'h1, 8'h00, 8'hff},
        '{LD, C, 2'h0, PPP_CMD_RD_SIG, 8'h00}, '{LD, A, 2'h0, 8'h00, 8'h00},
        '{RD, C, 2'h0, 8'h00, SIG0}, '{RD, C, 2'h1, 8'h00, CALIB},
        '{LD, A, 2'h0, 8'h01, 8'h00}, '{RD, C, 2'h0, 8'h00, SIG1},
        '{LD, A, 2'h0, 8'h02, 8'h00}, '{RD, C, 2'h0, 8'h00, SIG2},
        '{LD, C, 2'h0, PPP_CMD_WR_FUSE, 8'h00}, '{LD, D, 2'h0, 8'h3c, 8'h00},
        '{WR, C, 2'h0, 8'h00, 8'h00}, '{LD, D, 2'h0, 8'ha5, 8'h00},
        '{WR, C, 2'h1, 8'h00, 8'h00}, '{LD, D, 2'h0, 8'h00, 8'h00},
        '{WR, C, 2'h2, 8'h00, 8'h00},
        '{LD, C, 2'h0, PPP_CMD_WR_LOCK, 8'h00}, '{LD, D, 2'h0, 8'hfc, 8'h00},
        '{WR, C, 2'h0, 8'h00, 8'h00}, '{LD, D, 2'h0, 8'hf3, 8'h00},
        '{WR, C, 2'h0, 8'h00, 8'h00}, '{LD, C, 2'h0, PPP_CMD_RD_FL, 8'h00},
        '{RD, C, 2'h0, 8'h00, 8'h3c}, '{RD, C, 2'h3, 8'h00, 8'ha5},
        '{RD, C, 2'h1, 8'h00, 8'hf0},
        '{LD, C, 2'h0, PPP_CMD_ERASE, 8'h00}, '{WR, C, 2'h0, 8'h00, 8'h00},
        '{LD, C, 2'h0, PPP_CMD_RD_FL, 8'h00}, '{RD, C, 2'h1, 8'h00, 8'hff},
        '{RD, C, 2'h0, 8'h00, 8'h3c},
        '{LD, C, 2'h0, PPP_CMD_WR_FLASH, 8'h00}, '{LD, A, 2'h1, 8'h00, 8'h00},
        '{LD, A, 2'h0, 8'h21, 8'h00}, '{LD, D, 2'h0, 8'h34, 8'h00},
        '{LD, D, 2'h1, 8'h12, 8'h00}, '{LT, C, 2'h1, 8'h00, 8'h00},
        '{LD, A, 2'h0, 8'h22, 8'h00}, '{LD, D, 2'h0, 8'h78, 8'h00},
        '{LD, D, 2'h1, 8'h56, 8'h00}, '{LT, C, 2'h1, 8'h00, 8'h00},
        '{WR, C, 2'h0, 8'h00, 8'h00}, '{LD, C, 2'h0, PPP_CMD_NOP, 8'h00},
        '{LD, C, 2'h0, PPP_CMD_WR_EE, 8'h00}, '{LD, A, 2'h1, 8'h00, 8'h00},
        '{LD, A, 2'h0, 8'h05, 8'h00}, '{LD, D, 2'h0, 8'h9c, 8'h00},
        '{LT, C, 2'h0, 8'h00, 8'h00}, '{WR, C, 2'h0, 8'h00, 8'h00},
        '{LD, C, 2'h0, PPP_CMD_RD_FLASH, 8'h00}, '{LD, A, 2'h0, 8'h21, 8'h00},
        '{RD, C, 2'h0, 8'h00, 8'h34}, '{RD, C, 2'h1, 8'h00, 8'h12},
        '{LD, A, 2'h0, 8'h22, 8'h00}, '{RD, C, 2'h0, 8'h00, 8'h78},
        '{RD, C, 2'h1, 8'h00, 8'h56},
        '{LD, C, 2'h0, PPP_CMD_RD_EE, 8'h00}, '{LD, A, 2'h0, 8'h05, 8'h00},
        '{RD, C, 2'h0, 8'h00, 8'h9c}
    };

    ppp_if i_ppp_if ();

    ppp_device #(.SIG0(SIG0), .SIG1(SIG1), .SIG2(SIG2), .CALIB(CALIB),
                 .WRITE_CNT(PPP_CNT_W'(WR_CNT)), .ERASE_CNT(PPP_CNT_W'(ER_CNT))) i_ppp_device (
        .clk_in(clk_in), .rst_in(rst_in), .pins(i_ppp_if.dev),
        .command_out(cmd_seen), .busy_out(busy_seen));

    ppp_host i_ppp_host (
        .clk_in(clk_in), .rst_in(rst_in), .pins(i_ppp_if.host), .req_valid_in(req_valid),
        .req_op_in(req_op), .req_action_in(req_action), .req_bs1_in(req_bs1),
        .req_bs2_in(req_bs2), .req_data_in(req_data), .req_ready_out(req_ready),
        .rsp_data_out(rsp_data), .rsp_valid_out(rsp_valid));

    ppp_port_checker #(.WRITE_CNT(WR_CNT), .ERASE_CNT(ER_CNT)) i_ppp_port_checker (
        .clk_in(clk_in), .rst_in(rst_in), .action_select(i_ppp_if.action_select),
        .byte_select_one(i_ppp_if.byte_select_one), .byte_select_two(i_ppp_if.byte_select_two),
        .load_strobe(i_ppp_if.load_strobe), .write_n(i_ppp_if.write_n),
        .out_enable_n(i_ppp_if.out_enable_n), .host_data(i_ppp_if.host_data),
        .dev_data_oe_n(i_ppp_if.dev_data_oe_n), .ready_busy_flag(i_ppp_if.ready_busy_flag));

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic final_report();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // one request held until the host takes it; a read also waits for its answer
    task automatic do_req(input ppp_op_t op, input logic [1:0] act, input logic [1:0] sel,
                          input logic [7:0] d);
        @(negedge clk_in);
        req_op = op;
        {req_valid, req_action, req_bs2, req_bs1, req_data} = {1'h1, act, sel, d};
        while (req_ready !== 1'h1) @(negedge clk_in);
        @(negedge clk_in);
        req_valid = 1'h0;
        if (op == RD) begin
            while (rsp_valid !== 1'h1) @(negedge clk_in);
            rd_data = rsp_data;
        end
    endtask

    // free running clock, 100 ns period
    initial begin
        clk_in = 1'h0;
        forever #50 clk_in = ~clk_in;
    end

    // hang guard, far above the several hundred cycles the sequence needs
    initial begin
        forever begin
            @(posedge clk_in);
            cycles++;
            if (cycles == 20000) begin
                error_cnt++;
                final_report();
            end
        end
    end

    initial begin
        req_op = LD;
        {req_valid, req_action, req_bs2, req_bs1, req_data} = 13'h0;
        rst_in = 1'h1;
        repeat (3) @(negedge clk_in);
        rst_in = 1'h0;
        foreach (rows[i]) begin
            do_req(rows[i].op, rows[i].act, rows[i].sel, rows[i].d);
            if (rows[i].op == RD) check($sformatf("row %0d", i), rd_data, rows[i].exp);
        end
        // a no-op after latching must drop the buffered word before the page write
        do_req(LD, C, 2'h0, PPP_CMD_WR_FLASH);
        do_req(LD, A, 2'h0, 8'h40);
        do_req(LD, D, 2'h0, 8'h11);
        do_req(LT, C, 2'h1, 8'h00);
        do_req(LD, C, 2'h0, PPP_CMD_NOP);
        while (req_ready !== 1'h1) @(negedge clk_in);
        check("command after no-op", cmd_seen, PPP_CMD_NOP);
        do_req(LD, C, 2'h0, PPP_CMD_WR_FLASH);
        do_req(WR, C, 2'h0, 8'h00);
        do_req(LD, C, 2'h0, PPP_CMD_RD_FLASH);
        do_req(RD, C, 2'h0, 8'h00);
        check("flash after no-op", rd_data, 8'hff);
        // reset in the middle of a busy period must return both ends to ready
        do_req(LD, C, 2'h0, PPP_CMD_WR_LOCK);
        do_req(LD, D, 2'h0, 8'h00);
        do_req(WR, C, 2'h0, 8'h00);
        repeat (6) @(negedge clk_in);
        check("busy level", {7'h0, busy_seen}, 8'h01);
        check("ready mid write", {7'h0, i_ppp_if.ready_busy_flag}, 8'h00);
        rst_in = 1'h1;
        repeat (3) @(negedge clk_in);
        rst_in = 1'h0;
        check("ready after reset", {7'h0, i_ppp_if.ready_busy_flag}, 8'h01);
        do_req(LD, C, 2'h0, PPP_CMD_RD_FL);
        do_req(RD, C, 2'h0, 8'h00);
        check("fuse low after reset", rd_data, PPP_FUSE_LO_RST);
        final_report();
    end
endmodule
